// file: hdl/hbsp_device.sv
// Purpose: controller end of the strobe host port
// Assumes: pins synchronous to clk; host keeps its timing
// Notes:   user side is a simple memory access port
`timescale 1ns/100ps
`include "hbsp_defines.svh"
module hbsp_device
#(
   parameter int MS_CYC = `HBSP_HOLDOFF_MS_CYC
)
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // configuration
   input  wire hbsp_pkg::hbsp_style_t   style,
   input  wire logic                    irq_holdoff_scale,
   // host pins
   hbsp_bus_if.device                   bus,
   // user memory port
   output logic                         mem_rd,
   output logic                         mem_wr,
   output logic [`HBSP_ADDR_W-1:0]      mem_addr,
   output logic [`HBSP_DATA_W-1:0]      mem_wdata,
   input  wire logic [`HBSP_DATA_W-1:0] mem_rdata,
   // interrupt
   input  wire logic                    irq_req,
   input  wire logic                    interrupt_done_ack,
   output logic                         irq_out_n
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0]
   {
      HBSP_IDLE = 2'b00,
      HBSP_WAIT = 2'b01,
      HBSP_DONE = 2'b11
   } hbsp_dst_t;

   hbsp_dst_t               st_reg, st_next;
   logic                    rd_n_reg, wr_n_reg;
   logic [7:0]              lo_reg, lo_next;
   logic [`HBSP_ADDR_W-1:0] addr_reg, addr_next;
   logic [`HBSP_DATA_W-1:0] wd_reg, wd_next, dout_reg, dout_next;
   logic                    oe_reg, oe_next, rdy_n_reg, rdy_n_next;
   logic                    mrd_reg, mrd_next, mwr_reg, mwr_next;
   logic                    isrd_reg, isrd_next;
   logic [2:0]              wt_reg, wt_next;
   logic                    sel, rd_fall, wr_rise, strobes_off;
   logic                    wr_fall, wr_go;

   // select for current style
   function automatic logic dev_sel(hbsp_pkg::hbsp_style_t s,
                                    logic [`HBSP_ADDR_W-1:0] a,
                                    logic cs_n);
      if (s == hbsp_pkg::HBSP_SYNC_MUX)
         return a[`HBSP_CS_HI:`HBSP_CS_LO] == 8'h00;
      return !cs_n;
   endfunction

   // ****************************************
   // access control
   // ****************************************
   always_comb
   begin
      sel         = dev_sel(style, bus.addr_in, bus.chip_select_in_n);
      // read on fall, write on rise
      rd_fall     = rd_n_reg && !bus.read_strobe_n;
      wr_rise     = !wr_n_reg && bus.write_strobe_n;
      strobes_off = bus.read_strobe_n && bus.write_strobe_n;
      wr_fall     = wr_n_reg && !bus.write_strobe_n;
      // async write starts on the fall so ready comes while it is low
      wr_go       = (style == hbsp_pkg::HBSP_SYNC_MUX) ? wr_rise : wr_fall;
      st_next     = st_reg;
      lo_next     = lo_reg;
      addr_next   = addr_reg;
      wd_next     = wd_reg;
      dout_next   = dout_reg;
      oe_next     = oe_reg;
      rdy_n_next  = rdy_n_reg;
      mrd_next    = 1'b0;
      mwr_next    = 1'b0;
      isrd_next   = isrd_reg;
      wt_next     = wt_reg;
      // latch low address on ale fall
      // follows the bus while ale is high and holds from its fall, since
      // the host moves the shared bus on at the very edge ale falls
      if (style == hbsp_pkg::HBSP_SYNC_MUX && bus.ale)
         lo_next = bus.data_io;
      // write data sampled while strobe low
      if (!bus.write_strobe_n)
         wd_next = bus.data_io;
      unique case (st_reg)
         HBSP_IDLE:
         begin
            if (sel && (rd_fall || wr_go))
            begin
               addr_next = (style == hbsp_pkg::HBSP_SYNC_MUX) ?
                  {bus.addr_in[`HBSP_ADDR_W-1:8], lo_reg} : bus.addr_in;
               isrd_next = rd_fall;
               mrd_next  = rd_fall;
               mwr_next  = wr_rise && style == hbsp_pkg::HBSP_SYNC_MUX;
               wt_next   = rd_fall ? 3'(`HBSP_RD_WAIT) :
                                     3'(`HBSP_WR_WAIT);
               st_next   = HBSP_WAIT;
            end
         end
         HBSP_WAIT:
         begin
            if (isrd_reg)
            begin
               dout_next = mem_rdata;
               oe_next   = 1'b1;
            end
            if (wt_reg != 3'h0)
               wt_next = wt_reg - 3'h1;
            else
            begin
               // clocked ready, length by access type
               if (style == hbsp_pkg::HBSP_ASYNC_RDY)
                  rdy_n_next = 1'b0;
               st_next = HBSP_DONE;
            end
         end
         HBSP_DONE:
         begin
            // async write lands at strobe rise
            if (wr_rise && style == hbsp_pkg::HBSP_ASYNC_RDY)
               mwr_next = 1'b1;
            if (strobes_off)
            begin
               rdy_n_next = 1'b1;
               st_next    = HBSP_IDLE;
            end
         end
         default:
            st_next = HBSP_IDLE;
      endcase
      // release bus with read strobe high
      if (bus.read_strobe_n)
         oe_next = 1'b0;
      // ready off at once when strobes leave
      if (strobes_off)
         rdy_n_next = 1'b1;
   end

   // registers only
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg    <= HBSP_IDLE;
         rd_n_reg  <= 1'b1;
         wr_n_reg  <= 1'b1;
         lo_reg    <= 8'h00;
         addr_reg  <= '0;
         wd_reg    <= '0;
         dout_reg  <= '0;
         oe_reg    <= 1'b0;
         rdy_n_reg <= 1'b1;
         mrd_reg   <= 1'b0;
         mwr_reg   <= 1'b0;
         isrd_reg  <= 1'b0;
         wt_reg    <= 3'h0;
      end
      else
      begin
         st_reg    <= st_next;
         rd_n_reg  <= bus.read_strobe_n;
         wr_n_reg  <= bus.write_strobe_n;
         lo_reg    <= lo_next;
         addr_reg  <= addr_next;
         wd_reg    <= wd_next;
         dout_reg  <= dout_next;
         oe_reg    <= oe_next;
         rdy_n_reg <= rdy_n_next;
         mrd_reg   <= mrd_next;
         mwr_reg   <= mwr_next;
         isrd_reg  <= isrd_next;
         wt_reg    <= wt_next;
      end
   end

   hbsp_holdoff #(
      .US_CYC (`HBSP_HOLDOFF_US_CYC),
      .MS_CYC (MS_CYC)
   ) u_holdoff (
      .clk                (clk),
      .sys_rst            (sys_rst),
      .interrupt_done_ack (interrupt_done_ack),
      .irq_holdoff_scale  (irq_holdoff_scale),
      .irq_req            (irq_req),
      .irq_out_n          (irq_out_n)
   );

   // outputs from flops
   assign bus.access_ready_n = rdy_n_reg;
   assign bus.dev_data_o     = dout_reg;
   assign bus.dev_data_oe    = oe_reg;
   assign mem_rd             = mrd_reg;
   assign mem_wr             = mwr_reg;
   assign mem_addr           = addr_reg;
   assign mem_wdata          = wd_reg;
endmodule

// file: hdl/hbsp_defines.svh
// Purpose: constants for the host bus strobe port
// Assumes: 250 MHz system clock
// Notes:   times kept in their own unit, cycle counts derived
`ifndef HBSP_DEFINES_SVH
`define HBSP_DEFINES_SVH
`define HBSP_CLK_MHZ          250
`define HBSP_HOLDOFF_US       1
`define HBSP_HOLDOFF_MS       1
`define HBSP_HOLDOFF_US_CYC   (`HBSP_HOLDOFF_US * `HBSP_CLK_MHZ)
`define HBSP_HOLDOFF_MS_CYC   (`HBSP_HOLDOFF_MS * 1000 * `HBSP_CLK_MHZ)
`define HBSP_RESET_NS         100
`define HBSP_CLK_NS           4
`define HBSP_RESET_CYC        ((`HBSP_RESET_NS + `HBSP_CLK_NS - 1) / `HBSP_CLK_NS)
`define HBSP_CS_HI            10
`define HBSP_CS_LO            3
`define HBSP_RD_WAIT          4
`define HBSP_WR_WAIT          2
`define HBSP_SYNC_STROBE_CYC  6
`define HBSP_ADDR_W           11
`define HBSP_DATA_W           8
`endif

// file: hdl/hbsp_pkg.sv
// Purpose: shared types for the host bus strobe port
// Assumes: nothing
// Notes:   constants live in hbsp_defines.svh
package hbsp_pkg;
   // bus styles handled by both ends
   typedef enum logic
   {
      HBSP_SYNC_MUX  = 1'b0,
      HBSP_ASYNC_RDY = 1'b1
   } hbsp_style_t;
endpackage

// file: hdl/hbsp_bus_if.sv
// Purpose: pin-level carrier between host and controller
// Assumes: single clock domain
// Notes:   data bus resolved here from the two enables
`timescale 1ns/100ps
`include "hbsp_defines.svh"
interface hbsp_bus_if;
   logic [`HBSP_ADDR_W-1:0] addr_in;
   logic                    ale;
   logic                    read_strobe_n;
   logic                    write_strobe_n;
   logic                    chip_select_in_n;
   logic                    access_ready_n;
   logic [`HBSP_DATA_W-1:0] host_data_o;
   logic                    host_data_oe;
   logic [`HBSP_DATA_W-1:0] dev_data_o;
   logic                    dev_data_oe;
   logic [`HBSP_DATA_W-1:0] data_io;

   // wire level, host wins only if both drive (a fault)
   assign data_io = host_data_oe ? host_data_o :
                    dev_data_oe  ? dev_data_o  : '1;

   modport device (input addr_in, ale, read_strobe_n, write_strobe_n,
                   chip_select_in_n, data_io,
                   output access_ready_n, dev_data_o, dev_data_oe);
   modport host (output addr_in, ale, read_strobe_n, write_strobe_n,
                 chip_select_in_n, host_data_o, host_data_oe,
                 input access_ready_n, data_io);
endinterface

// file: hdl/hbsp_holdoff.sv
// Purpose: interrupt hold-off timer after end-of-interrupt
// Assumes: one pulse on ack restarts the wait
// Notes:   long count is a parameter so simulation can shorten it
`timescale 1ns/100ps
`include "hbsp_defines.svh"
module hbsp_holdoff
#(
   parameter int US_CYC = `HBSP_HOLDOFF_US_CYC,
   parameter int MS_CYC = `HBSP_HOLDOFF_MS_CYC
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // control
   input  wire logic interrupt_done_ack,
   input  wire logic irq_holdoff_scale,
   input  wire logic irq_req,
   // result
   output logic      irq_out_n
);
   logic [19:0] cnt_reg;
   logic [19:0] cnt_next;
   logic        irq_n_reg;
   logic        irq_n_next;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (interrupt_done_ack)
         cnt_next = irq_holdoff_scale ? 20'(MS_CYC) : 20'(US_CYC);
      else if (cnt_reg != 20'h00000)
         cnt_next = cnt_reg - 20'h00001;
      irq_n_next = ~(irq_req && cnt_next == 20'h00000
                     && !interrupt_done_ack);
   end

   // registers only
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt_reg   <= 20'h00000;
         irq_n_reg <= 1'b1;
      end
      else
      begin
         cnt_reg   <= cnt_next;
         irq_n_reg <= irq_n_next;
      end
   end

   assign irq_out_n = irq_n_reg;
endmodule

// file: hdl/hbsp_host.sv
// Purpose: host end driving the strobe port
// Assumes: one command at a time from the user side
// Notes:   sync style fixed timing, async waits for ready
`timescale 1ns/100ps
`include "hbsp_defines.svh"
module hbsp_host
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // configuration
   input  wire hbsp_pkg::hbsp_style_t   style,
   // command port
   input  wire logic                    cmd_valid,
   input  wire logic                    cmd_write,
   input  wire logic [`HBSP_ADDR_W-1:0] cmd_addr,
   input  wire logic [`HBSP_DATA_W-1:0] cmd_wdata,
   output logic                         cmd_ready,
   output logic                         rsp_valid,
   output logic [`HBSP_DATA_W-1:0]      rsp_rdata,
   // device pins
   hbsp_bus_if.host                     bus
);
   typedef enum logic [1:0]
   {
      HBSP_H_IDLE = 2'b00,
      HBSP_H_ALE  = 2'b01,
      HBSP_H_STB  = 2'b11,
      HBSP_H_END  = 2'b10
   } hbsp_hst_t;

   hbsp_hst_t               st_reg, st_next;
   logic [`HBSP_ADDR_W-1:0] a_reg, a_next;
   logic [`HBSP_DATA_W-1:0] d_reg, d_next, rd_reg, rd_next;
   logic                    w_reg, w_next, ale_reg, ale_next;
   logic                    rdn_reg, rdn_next, wrn_reg, wrn_next;
   logic                    oe_reg, oe_next, rv_reg, rv_next;
   logic [2:0]              cnt_reg, cnt_next;

   // sequencing
   always_comb
   begin
      st_next  = st_reg;
      a_next   = a_reg;
      d_next   = d_reg;
      w_next   = w_reg;
      ale_next = 1'b0;
      rdn_next = rdn_reg;
      wrn_next = wrn_reg;
      oe_next  = oe_reg;
      rd_next  = rd_reg;
      rv_next  = 1'b0;
      cnt_next = cnt_reg;
      unique case (st_reg)
         HBSP_H_IDLE:
            if (cmd_valid)
            begin
               a_next  = cmd_addr;
               d_next  = cmd_wdata;
               w_next  = cmd_write;
               // high address with low on shared bus
               oe_next = style == hbsp_pkg::HBSP_SYNC_MUX || cmd_write;
               ale_next = style == hbsp_pkg::HBSP_SYNC_MUX;
               st_next = HBSP_H_ALE;
            end
         HBSP_H_ALE:
         begin
            rdn_next = w_reg;
            wrn_next = !w_reg;
            oe_next  = w_reg;
            cnt_next = 3'(`HBSP_SYNC_STROBE_CYC);
            st_next  = HBSP_H_STB;
         end
         HBSP_H_STB:
         begin
            if (cnt_reg != 3'h0)
               cnt_next = cnt_reg - 3'h1;
            // fixed timing / wait for ready
            if ((style == hbsp_pkg::HBSP_SYNC_MUX && cnt_reg == 3'h0) ||
                (style == hbsp_pkg::HBSP_ASYNC_RDY && !bus.access_ready_n))
            begin
               rd_next  = bus.data_io;
               rv_next  = !w_reg;
               rdn_next = 1'b1;
               wrn_next = 1'b1;
               st_next  = HBSP_H_END;
            end
         end
         HBSP_H_END:
         begin
            oe_next = 1'b0;
            st_next = HBSP_H_IDLE;
         end
      endcase
   end

   // registers only
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg  <= HBSP_H_IDLE;
         a_reg   <= '0;
         d_reg   <= '0;
         w_reg   <= 1'b0;
         ale_reg <= 1'b0;
         rdn_reg <= 1'b1;
         wrn_reg <= 1'b1;
         oe_reg  <= 1'b0;
         rd_reg  <= '0;
         rv_reg  <= 1'b0;
         cnt_reg <= 3'h0;
      end
      else
      begin
         st_reg  <= st_next;
         a_reg   <= a_next;
         d_reg   <= d_next;
         w_reg   <= w_next;
         ale_reg <= ale_next;
         rdn_reg <= rdn_next;
         wrn_reg <= wrn_next;
         oe_reg  <= oe_next;
         rd_reg  <= rd_next;
         rv_reg  <= rv_next;
         cnt_reg <= cnt_next;
      end
   end

   // low byte on shared bus during address phase in sync style
   assign bus.addr_in          = a_reg;
   assign bus.ale              = ale_reg;
   assign bus.read_strobe_n    = rdn_reg;
   assign bus.write_strobe_n   = wrn_reg;
   assign bus.chip_select_in_n = 1'b0;
   assign bus.host_data_o      = (st_reg == HBSP_H_ALE) ? a_reg[7:0] : d_reg;
   assign bus.host_data_oe     = oe_reg;
   assign cmd_ready            = st_reg == HBSP_H_IDLE;
   assign rsp_valid            = rv_reg;
   assign rsp_rdata            = rd_reg;
endmodule

// file: dv/hbsp_assertions.sv
// Purpose: concurrent checks on the strobe port wires
// Assumes: one clock, synchronous active-high reset
// Notes:   watches the carrier signals, instantiated beside it
`timescale 1ns/100ps
`include "hbsp_defines.svh"
module hbsp_assertions
(
   // clock and reset
   input wire logic                    clk,
   input wire logic                    sys_rst,
   // configuration
   input wire hbsp_pkg::hbsp_style_t   style,
   // bus wires
   input wire logic [`HBSP_ADDR_W-1:0] addr_in,
   input wire logic                    ale,
   input wire logic                    read_strobe_n,
   input wire logic                    write_strobe_n,
   input wire logic                    access_ready_n,
   input wire logic                    host_data_oe,
   input wire logic                    dev_data_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ************************************************
   // steps of an access
   // ************************************************
   sequence s_async_rd;
      style == hbsp_pkg::HBSP_ASYNC_RDY && $fell(read_strobe_n);
   endsequence
   sequence s_strobe_end;
      ($rose(read_strobe_n) || $rose(write_strobe_n))
         && read_strobe_n && write_strobe_n;
   endsequence

   // ************************************************
   // checks
   // ************************************************
   chk_bus_no_fight: assert property (
      !(host_data_oe && dev_data_oe)) else $error("data bus driven twice");
   chk_rd_release: assert property (
      $rose(read_strobe_n) |=> !dev_data_oe)
      else $error("data bus kept after read");
   chk_idle_hiz: assert property (
      read_strobe_n && $past(read_strobe_n) |-> !dev_data_oe)
      else $error("data bus driven without read");
   chk_rdy_drop: assert property (
      s_strobe_end |=> access_ready_n) else $error("ready kept after strobe");
   chk_rdy_idle: assert property (
      read_strobe_n && write_strobe_n && $past(read_strobe_n)
         && $past(write_strobe_n) |-> access_ready_n)
      else $error("ready without strobe");
   chk_rd_wait: assert property (
      s_async_rd |-> access_ready_n [*3] ##[1:12] !access_ready_n)
      else $error("read ready timing wrong");
   chk_rd_data_on: assert property (
      !access_ready_n && !read_strobe_n |-> dev_data_oe)
      else $error("ready on read without data");
   chk_ale_addr: assert property (
      $fell(ale) |-> $stable(addr_in) && $past(host_data_oe))
      else $error("address not held at latch");
   chk_sync_strobe: assert property (
      style == hbsp_pkg::HBSP_SYNC_MUX && $fell(read_strobe_n)
         |-> !read_strobe_n [*5]) else $error("sync read strobe short");
   chk_strobe_excl: assert property (
      read_strobe_n || write_strobe_n) else $error("both strobes low");
endmodule

// file: dv/host_bus_strobe_port_tb_top.sv
// Purpose: host and controller ends joined, checked against a model
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   long hold-off shortened through MS_CYC
`timescale 1ns/100ps
`include "hbsp_defines.svh"
module host_bus_strobe_port_tb_top;
   localparam int MS_CYC = 50;
   localparam int US_CYC = `HBSP_HOLDOFF_US_CYC;
   logic                    clk = 1'b0;
   logic                    sys_rst = 1'b1;
   hbsp_pkg::hbsp_style_t   style = hbsp_pkg::HBSP_SYNC_MUX;
   logic                    irq_holdoff_scale = 1'b0;
   logic                    irq_req = 1'b0;
   logic                    interrupt_done_ack = 1'b0;
   logic                    cmd_valid = 1'b0;
   logic                    cmd_write = 1'b0;
   logic [`HBSP_ADDR_W-1:0] cmd_addr = '0;
   logic [`HBSP_DATA_W-1:0] cmd_wdata = '0;
   logic [`HBSP_DATA_W-1:0] mem_rdata = '0;
   logic                    cmd_ready, rsp_valid, mem_rd, mem_wr, irq_out_n;
   logic [`HBSP_DATA_W-1:0] rsp_rdata, mem_wdata;
   logic [`HBSP_ADDR_W-1:0] mem_addr, addr_tab [0:7];
   logic [7:0]              dev_mem [0:2047], ref_mem [0:2047];
   logic [19:0]             exp_q [$];
   logic [19:0]             op;
   logic [10:0]             lat_a = '0;
   logic                    ale_q = 1'b0;
   int                      n_errors = 0, checks = 0;
   int                      seed = 32'hb006ee27;

   // free-running clock, 4 ns period
   // one system clock
   always #2 clk = ~clk;

   hbsp_bus_if bus_if ();
   hbsp_device #(.MS_CYC(MS_CYC)) u_hbsp_device (.clk(clk),
      .sys_rst(sys_rst), .style(style),
      .irq_holdoff_scale(irq_holdoff_scale), .bus(bus_if.device),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
      .interrupt_done_ack(interrupt_done_ack), .irq_out_n(irq_out_n));
   hbsp_host u_hbsp_host (.clk(clk), .sys_rst(sys_rst), .style(style),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .bus(bus_if.host));
   hbsp_assertions u_hbsp_assertions (.clk(clk), .sys_rst(sys_rst),
      .style(style), .addr_in(bus_if.addr_in), .ale(bus_if.ale),
      .read_strobe_n(bus_if.read_strobe_n),
      .write_strobe_n(bus_if.write_strobe_n),
      .access_ready_n(bus_if.access_ready_n),
      .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));

   // ************************************************
   // compare and closing tasks
   // ************************************************
   task automatic cmp_data(input string what, input logic [15:0] exp,
                 input logic [15:0] seen);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmp_flag(input string what, input logic exp,
                           input logic seen);
      cmp_data(what, {15'h0000, exp}, {15'h0000, seen});
   endtask
   task automatic cmp_cnt(input string what, input int exp, input int seen);
      checks++;
      if (seen != exp)
      begin
         n_errors++;
         $display("BAD %s exp %0d seen %0d", what, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // user memory behind the controller; pops the expected access queue
   always @(posedge clk)
   begin
      #1;
      if (mem_wr === 1'b1 || mem_rd === 1'b1)
      begin
         op = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hfffff;
         cmp_data("mem access", {4'h0, op[19:8]}, {4'h0, mem_wr, mem_addr});
         if (mem_wr === 1'b1)
         begin
            cmp_data("mem wdata", {8'h00, op[7:0]}, {8'h00, mem_wdata});
            dev_mem[mem_addr] = mem_wdata;
         end
      end
      mem_rdata = dev_mem[mem_addr];
   end

   // low address byte standing on the shared bus while latch enable is high
   always @(posedge clk)
   begin
      ale_q <= bus_if.ale;
      if (ale_q === 1'b0 && bus_if.ale === 1'b1
          && style == hbsp_pkg::HBSP_SYNC_MUX)
         cmp_data("latched addr", {8'h00, lat_a[7:0]}, {8'h00, bus_if.data_io});
   end

   // one host command; refused selects read the pulled-up bus
   task do_cmd(input logic wr, input logic [10:0] a, input logic [7:0] d);
      logic       sel;
      logic [7:0] exp_r;
      int         n;
      sel = (style == hbsp_pkg::HBSP_ASYNC_RDY) || (a[10:3] == 8'h00);
      exp_r = sel ? ref_mem[a] : 8'hff;
      if (sel)
         exp_q.push_back({wr, a, d});
      if (sel && wr)
         ref_mem[a] = d;
      lat_a = a;
      // sync host does not pace itself; let the controller reach idle
      repeat (6) @(posedge clk);
      #1 cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      // writes give no response pulse; they end with the host back in idle
      while ((wr ? cmd_ready : rsp_valid) !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         #1 n++;
      end
      cmp_cnt("response wait", 1, n < 300);
      if (!wr)
         cmp_data("read data", {8'h00, exp_r}, {8'h00, rsp_rdata});
   endtask

   // hold-off after end-of-interrupt for one scale
   task irq_check(input logic scale, input int len);
      int n;
      irq_holdoff_scale = scale;
      irq_req = 1'b1;
      repeat (len + 5) @(posedge clk);
      #1 cmp_flag("irq active", 1'b0, irq_out_n);
      interrupt_done_ack = 1'b1;
      @(posedge clk);
      #1 interrupt_done_ack = 1'b0;
      n = 1;
      while (irq_out_n !== 1'b0 && n < len + 20)
      begin
         @(posedge clk);
         #1 n++;
      end
      cmp_flag("holdoff span", 1'b1, n >= len - 1 && n <= len + 3);
      irq_req = 1'b0;
      repeat (3) @(posedge clk);
      #1 cmp_flag("irq idle", 1'b1, irq_out_n);
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      for (int i = 0; i < 2048; i++)
      begin
         dev_mem[i] = i[7:0] ^ 8'h5a;
         ref_mem[i] = i[7:0] ^ 8'h5a;
      end
      repeat (5) @(posedge clk);
      #1 sys_rst = 1'b0;
      irq_check(1'b0, US_CYC);
      irq_check(1'b1, MS_CYC);
      for (int s = 0; s < 2; s++)
      begin
         style = s ? hbsp_pkg::HBSP_ASYNC_RDY : hbsp_pkg::HBSP_SYNC_MUX;
         // random writes then read-back in reverse order, six idle cycles before each
         for (int i = 0; i < 8; i++)
         begin
            addr_tab[i] = s ? 11'($random(seed)) : 11'(i);
            do_cmd(1'b1, addr_tab[i], 8'($random(seed)));
         end
         for (int i = 7; i >= 0; i--)
            do_cmd(1'b0, addr_tab[i], 8'h00);
         // outside the decoded window in sync style
         do_cmd(1'b1, 11'h108, 8'h3c);
         do_cmd(1'b0, 11'h0f8, 8'h00);
      end
      repeat (10) @(posedge clk);
      cmp_cnt("unserved accesses", 0, exp_q.size());
      report_and_stop();
   end

   // hang guard, far beyond the expected run of under two thousand cycles
   initial
   begin
      #100000;
      n_errors++;
      $display("BAD watchdog exp done seen hang");
      report_and_stop();
   end
endmodule
